/* File: ssrp_host.sv */
/*
  Host model: drives the serial clock, select and data pins.
  Assumes the bench resolves the data pin with a pull-up.
*/
`timescale 1ns/10ps

module ssrp_host (
  // Pins driven.
  output logic      scl_o,
  output logic      csn_o,
  output logic      sda_o,
  // Pins sensed.
  input  wire logic sda_i,
  input  wire logic miso_i
);
  // The clock stands still high between frames; half period is 32 ns.
  initial begin
    scl_o = 1'b1;
    csn_o = 1'b1;
    sda_o = 1'b1;
  end

  // Data changes only while the clock is low.
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #16 scl_o = 1'b1;
    #16 r = sda_i;
    #16 scl_o = 1'b0;
    #16;
  endtask

  // Start, also used as repeated start; the odd delay breaks phase lock.
  task automatic start();
    #1.3 sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b0;
    #16;
  endtask

  // Stop closes every two-wire transfer so samples may update.
  task automatic stop();
    sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 sda_o = 1'b1;
    #32;
  endtask

  // Eight bits then the answer bit; last is what the host puts in it.
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(last, ack);
  endtask

  // Select edges frame a shift transaction.
  task automatic sel(input logic on);
    if (on) begin
      #1.3 csn_o = 1'b0;
      #32;
    end else begin
      #32 csn_o = 1'b1;
      #32;
    end
  endtask

  // One shift byte, most significant bit first, captured before each rise.
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      scl_o = 1'b0;
      sda_o = tx[i];
      #32 rx[i] = miso_i;
      scl_o = 1'b1;
      #32;
    end
  endtask
endmodule // ssrp_host

/* File: ssrp_pkg.sv */
/*
  Types of the sensor serial register port: two-wire states, the register
  request carrier and the state records of both clock domains.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ssrp_pkg;

  // Two-wire slave states, one-hot.
  typedef enum logic [8:0] {
    SSRP_I2C_IDLE     = 9'h001,
    SSRP_I2C_ADDR     = 9'h002,
    SSRP_I2C_ADDR_ACK = 9'h004,
    SSRP_I2C_REG      = 9'h008,
    SSRP_I2C_REG_ACK  = 9'h010,
    SSRP_I2C_WDATA    = 9'h020,
    SSRP_I2C_WACK     = 9'h040,
    SSRP_I2C_RDATA    = 9'h080,
    SSRP_I2C_RACK     = 9'h100
  } ssrp_i2c_e;

  // One access to the register file, valid for one clock.
  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssrp_req_s;

  // System clock domain state.
  typedef struct packed {
    ssrp_i2c_e   st;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        rw;
    logic [7:0]  addr;
    logic        sda_low;
    logic        busy;
    logic        rd_cap;
    logic [7:0]  rd_buf;
    logic        spi_cap;
    logic [7:0]  spi_rd_buf;
    logic        spi_pend;
    logic        tgl_d;
    logic        scl_d;
    logic        sda_d;
    logic [31:0] wdt_cnt;
    logic        wdt_flag;
    logic [1:0]  strap_cnt;
    logic [6:0]  dev_addr;
    logic        hold;
    logic [1:0]  op_state;
    logic        int_srv;
    ssrp_req_s   req;
  } ssrp_sys_s;

  // Link clock domain state sampled on the rising edge.
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic       rw;
    logic [6:0] addr;
    logic [6:0] shreg;
    logic       req_tgl;
    logic       req_we;
    logic [6:0] req_addr;
    logic [7:0] req_data;
  } ssrp_spi_s;

  // Link clock domain state driven on the falling edge.
  typedef struct packed {
    logic [7:0] shout;
    logic       drv;
  } ssrp_spo_s;

endpackage

/* File: ssrp_port.sv */
/*
  Serial register access port: two-wire slave sampled on the system clock,
  three/four-wire shift slave clocked by the host's serial clock, and one
  register request port toward the register file in the system domain.
  Assumes the register file returns reg_rdata_i in the clock of a read
  request and that the two-wire host keeps the select pin high.
*/
`timescale 1ns/10ps
`include "ssrp_regs.svh"

// Function
// - Strap level picks address 0x4C or 0x6C.
// - Acknowledge matching write address on ninth clock.
// - Register address byte then stored data byte.
// - Repeated start with read bit returns register.
// - Two-wire multi-byte transfers increment register address.
// - Hold sample registers while bus is active.
// - Standby completes cycles; interrupts not serviced.
// - Drive read data until nine clocks counted; the port frees the line after the eighth clock.
// - Watchdog timeout resets two-wire logic, releases line.
// - Timeout sets only the watchdog flag.
// - Reading status register clears watchdog flag.
// - Shift write 16 clocks, read 24 clocks.
// - Select falling edge starts a new transaction.
// - Input data sampled on serial clock rising edge.
// - Output data changes on serial clock falling edge.
// - Shift data travels most significant bit first.
// - Write: bit zero, address, then data byte.
// - Read: bit one, address, then returned data.
// - Burst write increments address per further byte.
// - Burst read increments address per further byte.
// - Supports three-wire and four-wire shift variants.
// - Report operating state: 00 standby, 01 wake.
module ssrp_port
  import ssrp_pkg::*;
#(
  parameter int unsigned WDT_CYCLES = `SSRP_WDT_CYCLES
) (
  // System clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Serial clock pin, as link clock and as sampled two-wire clock.
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  // Active-low select pin.
  input  wire logic       select_low_pin_i,
  // Shared data pin (two-wire data, shift input, three-wire output).
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // Address-select strap and four-wire data output pin.
  input  wire logic       addr_select_out_pin_i,
  output logic            addr_select_out_pin_o,
  output logic            addr_select_out_pin_oe_n_o,
  // Configuration and state from the register file.
  input  wire logic       spi_3wire_en_i,
  input  wire logic       wdt_en_i,
  input  wire logic [1:0] op_state_i,
  // Register file access.
  output ssrp_req_s       reg_req_o,
  input  wire logic [7:0] reg_rdata_i,
  // Status toward the rest of the sensor.
  output logic            bus_watchdog_flag_o,
  output logic [7:0]      dev_status_o,
  output logic            sample_hold_o,
  output logic            int_service_en_o
);

  ssrp_sys_s  s;
  ssrp_sys_s  n;
  ssrp_spi_s  p;
  ssrp_spi_s  next_p;
  ssrp_spo_s  q;
  ssrp_spo_s  next_q;
  logic [4:0] sy;
  logic       spi_rst;
  logic       scl;
  logic       sda;
  logic       csn_low;
  logic       strap;
  logic       tgl;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       wr_ok;
  logic       timeout;

  // Pins pass two flops; clock and data go inverted so reset shows them idle high.
  ssrp_sync #(.W(5)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({p.req_tgl, addr_select_out_pin_i, ~select_low_pin_i, ~sda_i, ~scl_i}),
    .sync_o    (sy)
  );

  assign scl     = ~sy[0];
  assign sda     = ~sy[1];
  assign csn_low = sy[2];
  assign strap   = sy[3];
  assign tgl     = sy[4];

  // Bus events seen on the sampled pins.
  assign scl_rise = scl & ~s.scl_d;
  assign scl_fall = ~scl & s.scl_d;
  assign start    = scl & s.scl_d & s.sda_d & ~sda;
  assign stop     = scl & s.scl_d & ~s.sda_d & sda;

  // In wake only the mode register may change.
  assign wr_ok = (s.op_state == `SSRP_STATE_STANDBY) || (s.addr == `SSRP_MODE_ADDR);

  // Two-wire engine, request arbitration and status in the system domain.
  always_comb begin
    n           = s;
    n.req       = '0;
    n.rd_cap    = 1'b0;
    n.spi_cap   = 1'b0;
    timeout     = 1'b0;
    n.scl_d     = scl;
    n.sda_d     = sda;
    n.tgl_d     = tgl;
    n.op_state  = op_state_i;
    n.int_srv   = (op_state_i == `SSRP_STATE_WAKE);
    n.hold      = s.busy | csn_low;
    if (s.rd_cap) begin
      n.rd_buf = reg_rdata_i;
    end
    if (s.spi_cap) begin
      n.spi_rd_buf = reg_rdata_i;
    end
    // The strap is caught a few clocks after reset, once synchronised.
    if (s.strap_cnt < `SSRP_STRAP_CNT) begin
      n.strap_cnt = s.strap_cnt + 2'h1;
    end else if (s.st == SSRP_I2C_IDLE && !s.busy && s.strap_cnt == `SSRP_STRAP_CNT) begin
      n.strap_cnt = s.strap_cnt + 2'h1;
      n.dev_addr  = strap ? `SSRP_DEV_ADDR_HIGH : `SSRP_DEV_ADDR_LOW;
    end
    if (start) begin
      n.st      = SSRP_I2C_ADDR;
      n.bit_cnt = 4'h0;
      n.busy    = 1'b1;
      n.sda_low = 1'b0;
    end else if (stop) begin
      n.st      = SSRP_I2C_IDLE;
      n.busy    = 1'b0;
      n.sda_low = 1'b0;
    end else if (scl_rise) begin
      unique case (s.st)
        SSRP_I2C_ADDR, SSRP_I2C_REG, SSRP_I2C_WDATA: begin
          n.shreg   = {s.shreg[6:0], sda};
          n.bit_cnt = s.bit_cnt + 4'h1;
        end
        SSRP_I2C_RDATA: begin
          n.bit_cnt = s.bit_cnt + 4'h1;
        end
        SSRP_I2C_RACK: begin
          n.rw = ~sda;                     // Acknowledge from host means continue.
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (s.st)
        SSRP_I2C_ADDR: begin
          if (s.bit_cnt == 4'h8) begin
            if (s.shreg[7:1] == s.dev_addr) begin
              n.st      = SSRP_I2C_ADDR_ACK;
              n.sda_low = 1'b1;
              n.rw      = s.shreg[0];
              if (s.shreg[0]) begin
                n.req.re   = 1'b1;
                n.req.addr = s.addr;
                n.rd_cap   = 1'b1;
              end
            end else begin
              n.st = SSRP_I2C_IDLE;
            end
          end
        end
        SSRP_I2C_ADDR_ACK: begin
          n.bit_cnt = 4'h0;
          n.wdt_cnt = 32'h0000_0000;
          if (s.rw) begin
            n.st      = SSRP_I2C_RDATA;
            n.shreg   = s.rd_buf;
            n.sda_low = ~s.rd_buf[7];
          end else begin
            n.st      = SSRP_I2C_REG;
            n.sda_low = 1'b0;
          end
        end
        SSRP_I2C_REG: begin
          if (s.bit_cnt == 4'h8) begin
            n.addr    = s.shreg;
            n.st      = SSRP_I2C_REG_ACK;
            n.sda_low = 1'b1;
          end
        end
        SSRP_I2C_REG_ACK, SSRP_I2C_WACK: begin
          n.st      = SSRP_I2C_WDATA;
          n.bit_cnt = 4'h0;
          n.sda_low = 1'b0;
        end
        SSRP_I2C_WDATA: begin
          if (s.bit_cnt == 4'h8) begin
            n.req.we    = wr_ok;
            n.req.addr  = s.addr;
            n.req.wdata = s.shreg;
            n.addr      = s.addr + 8'h01;
            n.st        = SSRP_I2C_WACK;
            n.sda_low   = 1'b1;
          end
        end
        SSRP_I2C_RDATA: begin
          if (s.bit_cnt == 4'h8) begin
            // Line stays driven through the eighth bit, freed for the ninth.
            n.sda_low  = 1'b0;
            n.st       = SSRP_I2C_RACK;
            n.addr     = s.addr + 8'h01;
            n.req.re   = 1'b1;
            n.req.addr = s.addr + 8'h01;
            n.rd_cap   = 1'b1;
          end else begin
            n.shreg   = {s.shreg[6:0], 1'b0};
            n.sda_low = ~s.shreg[6];
          end
        end
        SSRP_I2C_RACK: begin
          n.bit_cnt = 4'h0;
          n.wdt_cnt = 32'h0000_0000;
          if (s.rw) begin
            n.st      = SSRP_I2C_RDATA;
            n.shreg   = s.rd_buf;
            n.sda_low = ~s.rd_buf[7];
          end else begin
            n.st = SSRP_I2C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    // Watchdog on a read that the host leaves unfinished.
    if (wdt_en_i && (s.st == SSRP_I2C_RDATA || s.st == SSRP_I2C_RACK) && !start && !stop) begin
      if (s.wdt_cnt >= 32'(WDT_CYCLES - 1)) begin
        timeout   = 1'b1;
        n.st      = SSRP_I2C_IDLE;
        n.sda_low = 1'b0;
        n.busy    = 1'b0;
        n.wdt_cnt = 32'h0000_0000;
      end else if (!scl_fall || s.st == SSRP_I2C_RDATA) begin
        n.wdt_cnt = s.wdt_cnt + 32'h0000_0001;
      end
    end else if (!(scl_fall && (s.st == SSRP_I2C_ADDR_ACK || s.st == SSRP_I2C_RACK))) begin
      n.wdt_cnt = 32'h0000_0000;
    end
    // Shift-port requests wait while a two-wire access uses the slot.
    if (s.spi_pend && !n.req.we && !n.req.re) begin
      n.spi_pend    = 1'b0;
      n.req.we      = p.req_we & ((s.op_state == `SSRP_STATE_STANDBY) ||
                      ({1'b0, p.req_addr} == `SSRP_MODE_ADDR));
      n.req.re      = ~p.req_we;
      n.req.addr    = {1'b0, p.req_addr};
      n.req.wdata   = p.req_data;
      n.spi_cap     = ~p.req_we;
    end
    if (tgl != s.tgl_d) begin
      n.spi_pend = 1'b1;
    end
    // Clear a clock after the read so the request still sees the flag; a timeout wins.
    if (s.req.re && s.req.addr == `SSRP_DEV_STAT_ADDR) begin
      n.wdt_flag = 1'b0;
    end
    if (timeout) begin
      n.wdt_flag = 1'b1;
    end
  end

  // System domain register.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s          <= '0;
      s.st       <= SSRP_I2C_IDLE;
      s.scl_d    <= 1'b1;
      s.sda_d    <= 1'b1;
      s.dev_addr <= `SSRP_DEV_ADDR_LOW;
    end else begin
      s <= n;
    end
  end

  // The shift port is held in reset whenever select is high.
  assign spi_rst = sys_rst_i | select_low_pin_i;

  // Rising-edge shift logic: command byte, then data bytes.
  always_comb begin
    next_p         = p;
    next_p.bit_cnt = p.bit_cnt + 3'h1;
    next_p.shreg   = {p.shreg[5:0], sda_i};
    if (p.bit_cnt == 3'h7) begin
      if (p.byte_cnt != 2'h2) begin
        next_p.byte_cnt = p.byte_cnt + 2'h1;
      end
      if (p.byte_cnt == 2'h0) begin
        next_p.rw   = p.shreg[6];
        next_p.addr = {p.shreg[5:0], sda_i};
        if (p.shreg[6]) begin
          next_p.req_tgl  = ~p.req_tgl;
          next_p.req_we   = 1'b0;
          next_p.req_addr = {p.shreg[5:0], sda_i};
        end
      end else if (!p.rw) begin
        next_p.req_tgl  = ~p.req_tgl;
        next_p.req_we   = 1'b1;
        next_p.req_addr = p.addr;
        next_p.req_data = {p.shreg, sda_i};
        next_p.addr     = p.addr + 7'h01;
      end
    end
    // On a read, the first bit of each byte from the third on fetches the following register.
    if (p.rw && p.byte_cnt == 2'h2 && p.bit_cnt == 3'h0) begin
      next_p.req_tgl  = ~p.req_tgl;
      next_p.req_we   = 1'b0;
      next_p.req_addr = p.addr + 7'h01;
      next_p.addr     = p.addr + 7'h01;
    end
  end

  // Request fields stay put from one toggle to the next, so the system
  // side can take them after the toggle crosses.
  always_ff @(posedge link_clk_i or posedge spi_rst) begin
    if (spi_rst) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  // Falling-edge output: load at byte start from the crossing buffer.
  always_comb begin
    next_q = q;
    if (p.rw && p.byte_cnt == 2'h2 && p.bit_cnt == 3'h0) begin
      next_q.shout = s.spi_rd_buf;
      next_q.drv   = 1'b1;
    end else begin
      next_q.shout = {q.shout[6:0], 1'b0};
    end
  end

  // Data is read at least 7.5 serial clocks after the request, long after it settles.
  always_ff @(negedge link_clk_i or posedge spi_rst) begin
    if (spi_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Pin drive: open-drain two-wire data, or shift output on either pin.
  always_comb begin
    if (spi_3wire_en_i && q.drv) begin
      sda_o      = q.shout[7];
      sda_oe_n_o = 1'b0;
    end else begin
      sda_o      = 1'b0;
      sda_oe_n_o = ~s.sda_low;
    end
    addr_select_out_pin_o      = q.shout[7];
    addr_select_out_pin_oe_n_o = ~(q.drv & ~spi_3wire_en_i);
  end

  // Outputs to the register file and the rest of the sensor.
  assign reg_req_o           = s.req;
  assign bus_watchdog_flag_o = s.wdt_flag;
  assign sample_hold_o       = s.hold;
  assign int_service_en_o    = s.int_srv;
  always_comb begin
    dev_status_o                                    = 8'h00;
    dev_status_o[`SSRP_STAT_WDT_BIT]                = s.wdt_flag;
    dev_status_o[`SSRP_STAT_STATE_LSB +: 2]         = s.op_state;
  end

endmodule // ssrp_port

/* File: ssrp_port_assertions.sv */
/*
  Checker of the serial register port, bound to every ssrp_port.
  Assumes only the port's pins, all in the system clock domain.
*/
`timescale 1ns/10ps
`include "ssrp_regs.svh"

module ssrp_port_assertions
  import ssrp_pkg::*;
(
  // Clock and reset.
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  // Pins and configuration.
  input wire logic       select_low_pin_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  input wire logic       addr_select_out_pin_oe_n_o,
  input wire logic       spi_3wire_en_i,
  input wire logic       wdt_en_i,
  input wire logic [1:0] op_state_i,
  // Register side and status.
  input wire ssrp_req_s  reg_req_o,
  input wire logic       bus_watchdog_flag_o,
  input wire logic [7:0] dev_status_o,
  input wire logic       sample_hold_o,
  input wire logic       int_service_en_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // The state input has settled, so registered copies may be compared.
  sequence state_settled;
    $stable(op_state_i)[*3];
  endsequence
  // A shift frame has been open long enough to pass the synchroniser.
  sequence select_held;
    !select_low_pin_i[*6];
  endsequence

  a_ack_drives_low: assert property (select_low_pin_i && $past(select_low_pin_i) && !sda_oe_n_o
    |-> !sda_o) else $error("two-wire data pin driven high");
  a_four_wire_out: assert property (!addr_select_out_pin_oe_n_o
    |-> !select_low_pin_i && !spi_3wire_en_i) else $error("output pin driven wrongly");
  a_three_wire_out: assert property (!sda_oe_n_o && !select_low_pin_i
    |-> spi_3wire_en_i) else $error("data pin driven in four-wire frame");
  a_status_state: assert property (state_settled
    |-> dev_status_o[1:0] == op_state_i) else $error("state field wrong");
  a_status_spare: assert property (dev_status_o[7:5] == 3'h0 && dev_status_o[3:2] == 2'h0
    && dev_status_o[4] == bus_watchdog_flag_o) else $error("status bits wrong");
  a_int_gate: assert property (state_settled
    |-> int_service_en_o == (op_state_i == `SSRP_STATE_WAKE)) else $error("gate wrong");
  a_wake_writes: assert property (state_settled ##0 (reg_req_o.we && op_state_i == `SSRP_STATE_WAKE)
    |-> reg_req_o.addr == `SSRP_MODE_ADDR) else $error("write accepted in wake");
  a_req_single: assert property (reg_req_o.we || reg_req_o.re
    |=> !(reg_req_o.we || reg_req_o.re)) else $error("request longer than one clock");
  a_hold_select: assert property (select_held
    |-> sample_hold_o) else $error("samples not held in frame");
  a_flag_cause: assert property ($rose(bus_watchdog_flag_o)
    |-> $past(wdt_en_i) && sda_oe_n_o) else $error("flag set without release");
  a_flag_clear: assert property (reg_req_o.re && reg_req_o.addr == `SSRP_DEV_STAT_ADDR
    |-> ##[1:2] !bus_watchdog_flag_o) else $error("flag kept after status read");
endmodule // ssrp_port_assertions

bind ssrp_port ssrp_port_assertions u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .select_low_pin_i(select_low_pin_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .spi_3wire_en_i(spi_3wire_en_i),
  .addr_select_out_pin_oe_n_o(addr_select_out_pin_oe_n_o), .wdt_en_i(wdt_en_i),
  .op_state_i(op_state_i), .reg_req_o(reg_req_o), .dev_status_o(dev_status_o),
  .bus_watchdog_flag_o(bus_watchdog_flag_o), .sample_hold_o(sample_hold_o),
  .int_service_en_o(int_service_en_o));

/* File: ssrp_port_tb.sv */
/*
  Bench of the serial register port with a host model and a register file.
  Assumes the host model drives every serial pin.
*/
`timescale 1ns/10ps

module ssrp_port_tb;
  import ssrp_pkg::*;
  // A short watchdog count keeps the stall scenario brief.
  localparam int WDT = 200;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        strap     = 1'b0;
  logic        three     = 1'b0;
  logic        wdt_en    = 1'b0;
  logic [1:0]  op_state  = 2'h0;
  logic        scl, select_low_pin, h_sda, sda_o, sda_oe_n, pin_o, pin_oe_n, flag, hold, isrv, ack;
  logic [7:0]  stat, ra, b0, b1, old, mem [256], sb [4], sr [4], wv [4];
  logic [31:0] v;
  ssrp_req_s   req;
  wire logic [7:0] rdata = (req.addr == 8'h05) ? stat : mem[req.addr];
  int          seed = 89, mismatches = 0, tests_run = 0, cyc = 0;
  // The data pin has a pull-up; the output pin shows the strap when released.
  wire logic   sda_w = (sda_oe_n | sda_o) & h_sda;
  wire logic   pin_w = pin_oe_n ? strap : pin_o;

  ssrp_host u_h (.scl_o(scl), .csn_o(select_low_pin), .sda_o(h_sda), .sda_i(sda_w),
                 .miso_i(three ? sda_w : pin_w));
  ssrp_port #(.WDT_CYCLES(WDT)) dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link_clk_i(scl), .scl_i(scl),
    .select_low_pin_i(select_low_pin), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .addr_select_out_pin_i(pin_w), .addr_select_out_pin_o(pin_o),
    .addr_select_out_pin_oe_n_o(pin_oe_n), .spi_3wire_en_i(three), .wdt_en_i(wdt_en),
    .op_state_i(op_state), .reg_req_o(req), .reg_rdata_i(rdata),
    .bus_watchdog_flag_o(flag), .dev_status_o(stat), .sample_hold_o(hold),
    .int_service_en_o(isrv));

  always #2 clk_sys_i = ~clk_sys_i;

  // Register file: stores writes on the clock, answers reads in the request's clock.
  always @(posedge clk_sys_i) begin
    if (req.we) mem[req.addr] <= req.wdata;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected status byte: watchdog flag in bit 4, operating state in bits 1:0.
  function automatic logic [7:0] exp_stat(input logic f, input logic [1:0] st);
    return {3'h0, f, 2'h0, st};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk_sys_i);
    strap     <= s;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
  endtask

  // Two-wire write of two bytes; ack keeps the address answer.
  task automatic i2c_wr(input logic [6:0] dev, input logic [7:0] r, d0, d1);
    logic [7:0] x;
    logic       a;
    u_h.start();
    u_h.xfer({dev, 1'b0}, 1'b1, x, ack);
    u_h.xfer(r, 1'b1, x, a);
    u_h.xfer(d0, 1'b1, x, a);
    u_h.xfer(d1, 1'b1, x, a);
    u_h.stop();
  endtask

  // Two-wire read of two bytes, or a read abandoned after three bits.
  task automatic i2c_rd(input logic [7:0] r, input logic stall);
    logic [7:0] x;
    logic       a;
    u_h.start();
    u_h.xfer(8'h98, 1'b1, x, a);
    u_h.xfer(r, 1'b1, x, a);
    u_h.start();
    u_h.xfer(8'h99, 1'b1, x, a);
    if (stall) begin
      repeat (3) u_h.bit_io(1'b1, a);
      repeat (WDT + 40) @(posedge clk_sys_i);
      check("freed early", {7'h00, sda_oe_n}, 8'h01);
    end else begin
      u_h.xfer(8'hFF, 1'b0, b0, a);
      u_h.xfer(8'hFF, 1'b1, b1, a);
    end
    u_h.stop();
  endtask

  task automatic spi_run();
    u_h.sel(1'b1);
    for (int k = 0; k < 4; k++) u_h.spi_byte(sb[k], sr[k]);
    u_h.sel(1'b0);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    do_reset(1'b0);
    check("status", stat, exp_stat(1'b0, 2'h0));
    for (int n = 0; n < 3; n++) begin
      v  = $random(seed);
      ra = {2'b01, v[5:0]};
      i2c_wr(7'h4C, ra, v[15:8], v[23:16]);
      check("addr ack", {7'h00, ack}, 8'h00);
      check("wr byte", mem[ra], v[15:8]);
      check("wr next", mem[ra + 8'h01], v[23:16]);
      i2c_rd(ra, 1'b0);
      check("rd byte", b0, v[15:8]);
      check("rd next", b1, v[23:16]);
    end
    i2c_wr(7'h6C, 8'h40, 8'hAA, 8'hAA);
    check("foreign addr", {7'h00, ack}, 8'h01);
    old = mem[8'h40];
    @(posedge clk_sys_i);
    op_state <= 2'h1;
    repeat (4) @(posedge clk_sys_i);
    check("wake gate", {7'h00, isrv}, 8'h01);
    check("wake state", stat, exp_stat(1'b0, 2'h1));
    i2c_wr(7'h4C, 8'h40, ~old, ~old);
    check("wake refuse", mem[8'h40], old);
    i2c_wr(7'h4C, 8'h07, 8'h01, 8'h5A);
    check("mode write", mem[8'h07], 8'h01);
    check("past mode", mem[8'h08], 8'h00);
    @(posedge clk_sys_i);
    op_state <= 2'h0;
    wdt_en   <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check("standby gate", {7'h00, isrv}, 8'h00);
    i2c_rd(8'h40, 1'b1);
    check("released", {7'h00, sda_oe_n}, 8'h01);
    check("flag only", stat, exp_stat(1'b1, 2'h0));
    check("untouched", mem[8'h40], old);
    i2c_rd(8'h05, 1'b0);
    check("status read", b0, exp_stat(1'b1, 2'h0));
    check("flag cleared", {7'h00, flag}, 8'h00);
    // Burst write then burst read, four-wire first, then three-wire.
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys_i);
      three <= m[0];
      v  = $random(seed);
      sb = '{{3'b010, v[4:0]}, v[15:8], v[23:16], v[31:24]};
      wv = sb;
      ra = {1'b0, wv[0][6:0]};
      spi_run();
      for (int k = 1; k < 4; k++) check("spi wr", mem[ra + 8'(k - 1)], wv[k]);
      sb = '{{1'b1, ra[6:0]}, 8'hFF, 8'hFF, 8'hFF};
      spi_run();
      for (int k = 2; k < 4; k++) check("spi rd", sr[k], wv[k - 1]);
      check("hold off", {7'h00, hold}, 8'h00);
    end
    do_reset(1'b1);
    i2c_wr(7'h6C, 8'h50, 8'h3C, 8'hC3);
    check("high strap", mem[8'h50], 8'h3C);
    i2c_wr(7'h4C, 8'h50, 8'h00, 8'h00);
    check("low addr off", {7'h00, ack}, 8'h01);
    tally_and_finish();
  end
endmodule // ssrp_port_tb

/* File: ssrp_regs.svh */
/*
  Constants of the sensor serial register port: bus addresses, register
  addresses, field positions, state codes and watchdog timing.
  Assumes it is included by bare name, possibly more than once; definitions only.
*/
`ifndef SSRP_REGS_SVH
`define SSRP_REGS_SVH

// Two-wire device addresses selected by the strap level at power-up.
`define SSRP_DEV_ADDR_LOW   7'h4C
`define SSRP_DEV_ADDR_HIGH  7'h6C

// Register addresses that the port itself acts upon.
`define SSRP_DEV_STAT_ADDR  8'h05
`define SSRP_MODE_ADDR      8'h07

// Device status register field positions.
`define SSRP_STAT_WDT_BIT   4
`define SSRP_STAT_STATE_LSB 0

// Operating state codes.
`define SSRP_STATE_STANDBY  2'h0
`define SSRP_STATE_WAKE     2'h1

// Watchdog time in milliseconds and system clock rate in MHz.
`define SSRP_WDT_TIME_MS    200
`define SSRP_CLK_MHZ        250
`define SSRP_WDT_CYCLES     (`SSRP_WDT_TIME_MS * 1000 * `SSRP_CLK_MHZ)

// Strap capture point, counted in clocks after reset release.
`define SSRP_STRAP_CNT      2'h2

`endif

/* File: ssrp_sync.sv */
/*
  Two-flop level synchroniser, one chain per bit.
  Assumes the inputs are levels that stay put for several destination clocks.
*/
`timescale 1ns/10ps

module ssrp_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  // Levels in and out.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // The first stage is read by the second stage only.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        meta[i]   <= 1'b0;
        sync_o[i] <= 1'b0;
      end else begin
        meta[i]   <= async_i[i];
        sync_o[i] <= meta[i];
      end
    end
  end

endmodule // ssrp_sync
